// ---- logic/ret_rot_consts.vh ----
// Constants for the return and rotate execution block
`ifndef RET_ROT_CONSTS_VH
`define RET_ROT_CONSTS_VH
// Operation codes presented by the decoder
`define OP_W 3
`define OP_NOP 3'h0
`define OP_RET_SUB 3'h1
`define OP_RET_LIT 3'h2
`define OP_RET_INT 3'h3
`define OP_ROT_LEFT 3'h4
// Widths
`define DATA_W 8
`define PC_W 10
`define RADDR_W 6
`define LVL_W 3
`define STACK_DEPTH 8
// Reset values
`define PC_RST 10'h000
`define BYTE_RST 8'h00
`define LVL_RST 3'h0
`define RADDR_RST 6'h00
`define FLAG_RST 1'b0
// Flag value written when a flag is set
`define FLAG_SET 1'b1
// Increments
`define PC_STEP 10'h001
`define LVL_STEP 3'h1
// Execute states
`define ST_W 1
`define ST_EXEC 1'h0
`define ST_FLUSH 1'h1
// Bit positions
`define MSB 7
`endif

// ---- logic/rotate_left_unit.v ----
// Rotate left through carry datapath
`timescale 1ns/1ns
`include "ret_rot_consts.vh"
module rotate_left_unit (
  input wire [7:0] operand,
  input wire carry_in,
  output wire [7:0] result,
  output wire carry_out
);
  // Old bit 7 leaves into carry, old carry enters bit 0
  assign result = {operand[`MSB-1:0], carry_in};
  assign carry_out = operand[`MSB];
endmodule // rotate_left_unit

// ---- logic/return_and_rotate_exec.v ----
// Execution of no-op, return forms and rotate left through carry
`timescale 1ns/1ns
`include "ret_rot_consts.vh"
module return_and_rotate_exec (
  input wire mclk,
  input wire resetn,
  input wire instr_valid,
  input wire [2:0] op_code,
  input wire [7:0] literal,
  input wire [5:0] reg_addr,
  input wire dest_sel,
  input wire [7:0] reg_rdata,
  input wire push_en,
  input wire [9:0] push_addr,
  output reg [9:0] pc_reg,
  output reg [7:0] accumulator_reg,
  output reg carry_reg,
  output reg global_interrupt_enable_reg,
  output reg [2:0] stack_level_reg,
  output reg reg_we_reg,
  output reg [5:0] reg_waddr_reg,
  output reg [7:0] reg_wdata_reg,
  output reg discard_reg,
  output reg busy_reg
);
  // Hardware stack entries, indexed by level; level 0 is written only by reset or by a push at level 7
  reg [9:0] stack_mem [0:7];
  // Entry at the current level, the address every return form pops
  wire [9:0] stack_top;
  // Execute state: one cycle for most work, a second to flush after a return
  reg [0:0] state_reg;
  reg [0:0] state_next;
  // Program counter next value
  reg [9:0] pc_next;
  // Accumulator and carry next values
  reg [7:0] accumulator_next;
  reg carry_next;
  // Interrupt enable next value, only ever set here
  reg global_interrupt_enable_next;
  // Stack level next value
  reg [2:0] stack_level_next;
  // Register-file write strobe, address and data for the next cycle
  reg reg_we_next;
  reg [5:0] reg_waddr_next;
  reg [7:0] reg_wdata_next;
  // Drop request for the word fetched behind a return
  reg discard_next;
  // Rotator outputs
  wire [7:0] rot_result;
  wire rot_carry;
  // Loop index for stack reset
  integer i;

  // Counter increment helper
  function [9:0] pc_inc;
    input [9:0] pc;
    begin
      pc_inc = pc + `PC_STEP;
    end
  endfunction

  // Level after a pop; an empty stack wraps, as there is no underflow guard
  function [2:0] level_pop;
    input [2:0] level;
    begin
      level_pop = level - `LVL_STEP;
    end
  endfunction

  // Pop address, read straight from the entry at the current level
  assign stack_top = stack_mem[stack_level_reg];

  // Rotate datapath; the operand arrives from the register file in the
  // same cycle, so the result is ready for the edge that takes the request
  rotate_left_unit u_rotate_left_unit (
    .operand(reg_rdata),
    .carry_in(carry_reg),
    .result(rot_result),
    .carry_out(rot_carry)
  );

  // Next-state decode. Every next value starts from its register, so a
  // request that is not taken leaves the state as it stands; the write
  // strobe and the discard flag default low so that each pulses for one
  // cycle only.
  always @* begin
    state_next = state_reg;
    pc_next = pc_reg;
    accumulator_next = accumulator_reg;
    carry_next = carry_reg;
    global_interrupt_enable_next = global_interrupt_enable_reg;
    stack_level_next = stack_level_reg;
    reg_we_next = 1'b0;
    reg_waddr_next = reg_waddr_reg;
    reg_wdata_next = reg_wdata_reg;
    discard_next = 1'b0;
    case (state_reg)
      `ST_EXEC: begin
        if (push_en) begin
          // Call side pushes return address; it wins over a request
          stack_level_next = stack_level_reg + `LVL_STEP;
        end else if (instr_valid) begin
          // Decode the accepted request
          case (op_code)
            `OP_NOP: begin
              // Nothing but the counter moves
              pc_next = pc_inc(pc_reg);
            end
            `OP_RET_SUB: begin
              // Pop only; flags stay as they are
              pc_next = stack_top;
              stack_level_next = level_pop(stack_level_reg);
              state_next = `ST_FLUSH;
              discard_next = 1'b1;
            end
            `OP_RET_LIT: begin
              // Pop, load the immediate and enable interrupts
              accumulator_next = literal;
              global_interrupt_enable_next = `FLAG_SET;
              pc_next = stack_top;
              stack_level_next = level_pop(stack_level_reg);
              state_next = `ST_FLUSH;
              discard_next = 1'b1;
            end
            `OP_RET_INT: begin
              // Pop and enable interrupts
              global_interrupt_enable_next = `FLAG_SET;
              pc_next = stack_top;
              stack_level_next = level_pop(stack_level_reg);
              state_next = `ST_FLUSH;
              discard_next = 1'b1;
            end
            `OP_ROT_LEFT: begin
              // One-cycle rotate; carry is the only flag it touches
              carry_next = rot_carry;
              pc_next = pc_inc(pc_reg);
              if (dest_sel) begin
                // Write back into addressed register
                reg_we_next = 1'b1;
                reg_waddr_next = reg_addr;
                reg_wdata_next = rot_result;
              end else begin
                // Result goes to the accumulator
                accumulator_next = rot_result;
              end
            end
            default: begin
              // Other opcodes belong to other units
              pc_next = pc_reg;
            end
          endcase
        end
      end
      `ST_FLUSH: begin
        // Second cycle: fetched word is dropped; neither a request nor a
        // push is taken here, so the popped address and level stand
        discard_next = 1'b0;
        state_next = `ST_EXEC;
      end
      default: begin
        state_next = `ST_EXEC;
      end
    endcase
  end

  // Stack storage write on push. The new entry goes one above the current
  // level, so a pop reads it back at that level once the level has risen.
  // Pushes are not taken in the flush cycle, matching the level update.
  always @(posedge mclk) begin
    if (!resetn) begin
      // Clear every entry so a stray pop returns a known address
      for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
        stack_mem[i] <= `PC_RST;
      end
    end else if (push_en && state_reg == `ST_EXEC) begin
      // Store the pushed return address
      stack_mem[stack_level_reg + `LVL_STEP] <= push_addr;
    end
  end

  // State registers; every output of the block is one of these
  always @(posedge mclk) begin
    if (!resetn) begin
      // Clear the architectural state
      state_reg <= `ST_EXEC;
      pc_reg <= `PC_RST;
      accumulator_reg <= `BYTE_RST;
      carry_reg <= `FLAG_RST;
      global_interrupt_enable_reg <= `FLAG_RST;
      stack_level_reg <= `LVL_RST;
      reg_we_reg <= `FLAG_RST;
      reg_waddr_reg <= `RADDR_RST;
      reg_wdata_reg <= `BYTE_RST;
      discard_reg <= `FLAG_RST;
      busy_reg <= `FLAG_RST;
    end else begin
      // Load the decoded next values
      state_reg <= state_next;
      pc_reg <= pc_next;
      accumulator_reg <= accumulator_next;
      carry_reg <= carry_next;
      global_interrupt_enable_reg <= global_interrupt_enable_next;
      stack_level_reg <= stack_level_next;
      reg_we_reg <= reg_we_next;
      reg_waddr_reg <= reg_waddr_next;
      reg_wdata_reg <= reg_wdata_next;
      discard_reg <= discard_next;
      // Busy marks the flush cycle that follows a return
      busy_reg <= (state_next == `ST_FLUSH);
    end
  end
endmodule // return_and_rotate_exec

// ---- tb/ret_rot_chk.sv ----
// Checker for the return and rotate execution block
`timescale 1ns/1ns
module ret_rot_chk (
  input wire mclk, input wire resetn, input wire instr_valid, input wire [2:0] op_code,
  input wire [7:0] literal, input wire dest_sel, input wire [7:0] reg_rdata, input wire push_en,
  input wire [9:0] pc_reg, input wire [7:0] accumulator_reg, input wire carry_reg,
  input wire global_interrupt_enable_reg, input wire [2:0] stack_level_reg,
  input wire reg_we_reg, input wire [7:0] reg_wdata_reg, input wire discard_reg, input wire busy_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire take = instr_valid && !busy_reg && !push_en; // Request accepted
  wire ret = take && op_code >= 3'h1 && op_code <= 3'h3; // Any return form
  wire rot = take && op_code == 3'h4; // Rotate accepted
  wire msb = reg_rdata[7]; // Operand top bit
  // Return: flush cycle then back to execute
  sequence s_pop;
    discard_reg && busy_reg ##1 !discard_reg && !busy_reg;
  endsequence
  AST_NOP: assert property (take && op_code == 3'h0 |=> pc_reg == $past(pc_reg) + 10'h001
    && $stable(accumulator_reg) && $stable(carry_reg)) else $error("nop changed state");
  AST_LIT_ACC: assert property (take && op_code == 3'h2 |=> accumulator_reg == $past(literal)
    ##1 !busy_reg) else $error("literal return wrong");
  AST_LIT_GIE: assert property (take && op_code == 3'h2 |=> global_interrupt_enable_reg)
    else $error("literal return left enable clear");
  AST_INT: assert property (take && op_code == 3'h3 |=> global_interrupt_enable_reg ##0 s_pop)
    else $error("interrupt return wrong");
  AST_SUB: assert property (take && op_code == 3'h1 |=> $stable(global_interrupt_enable_reg)
    && $stable(carry_reg) ##0 s_pop) else $error("subroutine return wrong");
  AST_POP: assert property (ret |=> stack_level_reg == 3'($past(stack_level_reg) - 3'h1))
    else $error("stack level not decremented");
  AST_ROT_REG: assert property (rot && dest_sel |=> reg_we_reg && carry_reg == $past(msb)
    && reg_wdata_reg == 8'({$past(reg_rdata), $past(carry_reg)})) else $error("rotate wrong");
  AST_ROT_ACC: assert property (rot && !dest_sel |=> !reg_we_reg && !busy_reg
    && accumulator_reg == 8'({$past(reg_rdata), $past(carry_reg)})) else $error("rotate dest");
  AST_DISCARD: assert property (ret |=> s_pop) else $error("fetch not discarded");
  AST_FLUSH_HOLD: assert property (busy_reg |=> $stable(pc_reg) && $stable(accumulator_reg)
    && $stable(carry_reg) && !reg_we_reg) else $error("flush cycle took a request");
endmodule // ret_rot_chk
bind return_and_rotate_exec ret_rot_chk u_ret_rot_chk (
  .mclk(mclk),
  .resetn(resetn),
  .instr_valid(instr_valid),
  .op_code(op_code),
  .literal(literal),
  .dest_sel(dest_sel),
  .reg_rdata(reg_rdata),
  .push_en(push_en),
  .pc_reg(pc_reg),
  .accumulator_reg(accumulator_reg),
  .carry_reg(carry_reg),
  .global_interrupt_enable_reg(global_interrupt_enable_reg),
  .stack_level_reg(stack_level_reg),
  .reg_we_reg(reg_we_reg),
  .reg_wdata_reg(reg_wdata_reg),
  .discard_reg(discard_reg),
  .busy_reg(busy_reg)
);

// ---- tb/return_and_rotate_exec_tb_top.sv ----
// Self-checking bench for the return and rotate execution block
`timescale 1ns/1ns
module return_and_rotate_exec_tb_top;
  reg mclk = 1'b0, resetn = 1'b0, instr_valid = 1'b0, dest_sel = 1'b0, push_en = 1'b0;
  reg [2:0] op_code = 3'h0;
  reg [7:0] literal = 8'h00, reg_rdata = 8'h00;
  reg [5:0] reg_addr = 6'h2a;
  reg [9:0] push_addr = 10'h000;
  wire [9:0] pc_reg;
  wire [7:0] accumulator_reg, reg_wdata_reg;
  wire [5:0] reg_waddr_reg;
  wire [2:0] stack_level_reg;
  wire carry_reg, global_interrupt_enable_reg, reg_we_reg, discard_reg, busy_reg;
  integer fails = 0, cmp_count = 0;
  return_and_rotate_exec u_return_and_rotate_exec (
    .mclk(mclk),
    .resetn(resetn),
    .instr_valid(instr_valid),
    .op_code(op_code),
    .literal(literal),
    .reg_addr(reg_addr),
    .dest_sel(dest_sel),
    .reg_rdata(reg_rdata),
    .push_en(push_en),
    .push_addr(push_addr),
    .pc_reg(pc_reg),
    .accumulator_reg(accumulator_reg),
    .carry_reg(carry_reg),
    .global_interrupt_enable_reg(global_interrupt_enable_reg),
    .stack_level_reg(stack_level_reg),
    .reg_we_reg(reg_we_reg),
    .reg_waddr_reg(reg_waddr_reg),
    .reg_wdata_reg(reg_wdata_reg),
    .discard_reg(discard_reg),
    .busy_reg(busy_reg)
  );
  initial begin
    forever #50 mclk = ~mclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // Hold a request for n edges; extra edges take it again unless they fall in a flush cycle
  task run_op(input [2:0] op, input [7:0] lit, input d, input [7:0] rd, input integer n);
    begin
      @(posedge mclk);
      instr_valid <= 1'b1; op_code <= op; literal <= lit; dest_sel <= d; reg_rdata <= rd;
      repeat (n) @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
    end
  endtask
  task push(input [9:0] a);
    begin
      @(posedge mclk);
      push_en <= 1'b1; push_addr <= a;
      @(posedge mclk);
      push_en <= 1'b0;
    end
  endtask
  task do_reset;
    begin
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
    end
  endtask
  task t_rotate;
    begin
      run_op(3'h4, 8'h00, 1'b1, 8'ha5, 1);
      check({reg_we_reg, reg_waddr_reg, reg_wdata_reg, carry_reg}, {1'b1, 6'h2a, 8'h4a, 1'b1});
      run_op(3'h4, 8'h00, 1'b0, 8'h81, 1);
      check({accumulator_reg, carry_reg, reg_we_reg}, {8'h03, 1'b1, 1'b0});
      check(pc_reg, 10'h002);
    end
  endtask
  task t_nop;
    begin
      run_op(3'h0, 8'hff, 1'b1, 8'hff, 1);
      check({pc_reg, accumulator_reg, carry_reg}, {10'h003, 8'h03, 1'b1});
      check({stack_level_reg, global_interrupt_enable_reg, reg_we_reg}, {3'h0, 1'b0, 1'b0});
    end
  endtask
  // Return, with a rotate of 8'hff shown as the fetched word in the flush cycle
  task ret_op(input [2:0] op, input [7:0] lit);
    begin
      @(posedge mclk);
      instr_valid <= 1'b1; op_code <= op; literal <= lit; dest_sel <= 1'b0; reg_rdata <= 8'hff;
      @(posedge mclk);
      op_code <= 3'h4;
      #1;
      check({discard_reg, busy_reg}, 2'b11);
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      check({discard_reg, busy_reg}, 2'b00);
    end
  endtask
  task t_returns;
    begin
      push(10'h155);
      push(10'h2aa);
      ret_op(3'h1, 8'h00);
      check({pc_reg, stack_level_reg, global_interrupt_enable_reg}, {10'h2aa, 3'h1, 1'b0});
      check({carry_reg, accumulator_reg}, {1'b1, 8'h03});
      ret_op(3'h2, 8'h55);
      check({pc_reg, stack_level_reg, accumulator_reg}, {10'h155, 3'h0, 8'h55});
      check({global_interrupt_enable_reg, carry_reg}, 2'b11);
    end
  endtask
  task t_int_return;
    begin
      do_reset;
      push(10'h3c3);
      ret_op(3'h3, 8'h00);
      check({pc_reg, stack_level_reg, global_interrupt_enable_reg}, {10'h3c3, 3'h0, 1'b1});
      check({carry_reg, accumulator_reg}, {1'b0, 8'h00});
    end
  endtask
  initial begin
    #200000;
    fails = fails + 1;
    finish_test;
  end
  initial begin
    do_reset;
    t_rotate;
    t_nop;
    t_returns;
    t_int_return;
    finish_test;
  end
endmodule // return_and_rotate_exec_tb_top
